// ---- logic/rcr_control_regs.sv ----
/*
 * Control-page registers: main control, interrupt enables, interrupt
 * flags and the interrupt output, reached over the serial link.
 * Assumes event inputs are single-cycle pulses on the system clock.
 */
module rcr_control_regs
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic alarm_match_in,
    input wire logic countdown_zero_in,
    input wire logic low_volt_threshold_one_in,
    input wire logic low_volt_threshold_two_in,
    input wire logic self_recovery_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic irq_out,
    output logic clock_output_pin_sel_out,
    output logic [1:0] timer_source_select_out,
    output logic self_recovery_enable_out,
    output logic hourly_refresh_enable_out,
    output logic timer_autoreload_enable_out,
    output logic countdown_enable_out,
    output logic watch_tick_enable_out
);
    logic [7:0] main_control;
    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_flags;
    logic rx_valid;
    logic rx_first;
    logic [7:0] rx_byte;
    logic frame_active;
    logic [7:0] tx_byte;
    logic [rcr_pkg::ADDR_W-1:0] addr;
    logic read_cmd;
    logic wr_strobe;
    logic [7:0] events;
    logic [7:0] clear_mask;

    rcr_serial_link u_link
    (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .tx_byte_in(tx_byte),
        .rx_valid_out(rx_valid),
        .rx_first_out(rx_first),
        .rx_byte_out(rx_byte),
        .frame_active_out(frame_active),
        .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out)
    );

    function automatic logic [7:0] read_reg(input logic [rcr_pkg::ADDR_W-1:0] a,
                                            input logic [7:0] ctl,
                                            input logic [7:0] en,
                                            input logic [7:0] fl);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            rcr_pkg::OFS_MAIN_CONTROL: d = ctl;
            rcr_pkg::OFS_INTERRUPT_ENABLE: d = en & rcr_pkg::IRQ_IMPL_MASK;
            rcr_pkg::OFS_INTERRUPT_FLAGS: d = fl & rcr_pkg::IRQ_IMPL_MASK;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // --------------------------------------------------------------
    // Command decode and address auto-increment
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            addr <= '0;
            read_cmd <= 1'b0;
            tx_byte <= 8'h00;
        end
        else if (rx_valid && rx_first)
        begin
            addr <= rx_byte[rcr_pkg::ADDR_W-1:0];
            read_cmd <= rx_byte[rcr_pkg::CMD_READ_BIT];
            tx_byte <= read_reg(rx_byte[rcr_pkg::ADDR_W-1:0], main_control,
                                interrupt_enable, interrupt_flags);
        end
        else if (rx_valid)
        begin
            addr <= addr + 1'b1;
            // Next byte sampled on the same edge this write lands, from the register values before it
            tx_byte <= read_reg(addr + 1'b1, main_control, interrupt_enable,
                                interrupt_flags);
        end
    end

    assign wr_strobe = rx_valid && !rx_first && !read_cmd && frame_active;

    // --------------------------------------------------------------
    // Main control and enables
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            main_control <= rcr_pkg::RST_MAIN_CONTROL;
            interrupt_enable <= rcr_pkg::RST_INTERRUPT_ENABLE;
        end
        else if (wr_strobe)
        begin
            if (addr == rcr_pkg::OFS_MAIN_CONTROL)
            begin
                main_control <= rx_byte;
            end
            if (addr == rcr_pkg::OFS_INTERRUPT_ENABLE)
            begin
                interrupt_enable <= rx_byte & rcr_pkg::IRQ_IMPL_MASK;
            end
        end
    end

    // --------------------------------------------------------------
    // Flags: set by events, cleared by writing zero; set beats clear
    // --------------------------------------------------------------
    always_comb
    begin
        events = 8'h00;
        events[rcr_pkg::IRQ_ALARM] = alarm_match_in;
        events[rcr_pkg::IRQ_COUNTDOWN] = countdown_zero_in;
        events[rcr_pkg::IRQ_LOW_VOLT_ONE] = low_volt_threshold_one_in;
        events[rcr_pkg::IRQ_LOW_VOLT_TWO] = low_volt_threshold_two_in;
        events[rcr_pkg::IRQ_SELF_RECOVERY] = self_recovery_in;
        clear_mask = 8'h00;
        if (wr_strobe && addr == rcr_pkg::OFS_INTERRUPT_FLAGS)
        begin
            clear_mask = ~rx_byte;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            interrupt_flags <= rcr_pkg::RST_INTERRUPT_FLAGS;
        end
        else
        begin
            interrupt_flags <= ((interrupt_flags & ~clear_mask) | events)
                               & rcr_pkg::IRQ_IMPL_MASK;
        end
    end

    // --------------------------------------------------------------
    // Interrupt output, silent while the pin is in clock-out mode
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= (|(interrupt_flags & interrupt_enable))
                       && !main_control[rcr_pkg::CTL_CLOCK_OUTPUT_SEL];
        end
    end

    assign clock_output_pin_sel_out = main_control[rcr_pkg::CTL_CLOCK_OUTPUT_SEL];
    assign timer_source_select_out = main_control[rcr_pkg::CTL_TIMER_SOURCE_HI:
                                                  rcr_pkg::CTL_TIMER_SOURCE_LO];
    assign self_recovery_enable_out = main_control[rcr_pkg::CTL_SELF_RECOVERY_EN];
    assign hourly_refresh_enable_out = main_control[rcr_pkg::CTL_HOURLY_REFRESH_EN];
    assign timer_autoreload_enable_out = main_control[rcr_pkg::CTL_TIMER_AUTORELOAD];
    assign countdown_enable_out = main_control[rcr_pkg::CTL_COUNTDOWN_EN];
    assign watch_tick_enable_out = main_control[rcr_pkg::CTL_WATCH_TICK_EN];

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    a_timer_flag_set: assert property (
        countdown_zero_in |=> interrupt_flags[rcr_pkg::IRQ_COUNTDOWN])
        else $error("timer flag not set after countdown event");
    a_timer_flag_hold: assert property (
        !interrupt_flags[rcr_pkg::IRQ_COUNTDOWN] && !countdown_zero_in
        |=> !interrupt_flags[rcr_pkg::IRQ_COUNTDOWN])
        else $error("timer flag set without countdown event");
    a_timer_flag_clear: assert property (
        wr_strobe && addr == rcr_pkg::OFS_INTERRUPT_FLAGS
        && !rx_byte[rcr_pkg::IRQ_COUNTDOWN] && !countdown_zero_in
        |=> !interrupt_flags[rcr_pkg::IRQ_COUNTDOWN])
        else $error("timer flag not cleared by write of zero");
    a_timer_gate: assert property (
        interrupt_flags[rcr_pkg::IRQ_COUNTDOWN] && interrupt_enable[rcr_pkg::IRQ_COUNTDOWN]
        && !main_control[rcr_pkg::CTL_CLOCK_OUTPUT_SEL] |=> irq_out)
        else $error("enabled timer flag did not raise interrupt");
    a_lv2_gate: assert property (
        interrupt_flags[rcr_pkg::IRQ_LOW_VOLT_TWO]
        && interrupt_enable[rcr_pkg::IRQ_LOW_VOLT_TWO]
        && !main_control[rcr_pkg::CTL_CLOCK_OUTPUT_SEL] |=> irq_out)
        else $error("enabled low voltage two flag did not raise interrupt");
    a_lv1_cause: assert property (
        !interrupt_flags[rcr_pkg::IRQ_LOW_VOLT_ONE]
        ##1 interrupt_flags[rcr_pkg::IRQ_LOW_VOLT_ONE]
        |-> $past(low_volt_threshold_one_in))
        else $error("low voltage one flag set without cause");
    a_unused_zero: assert property (
        (interrupt_enable[7:5] == 3'h0) && (interrupt_flags[7:5] == 3'h0))
        else $error("unimplemented bits not zero");
    a_irq_cause: assert property (
        $rose(irq_out) |-> $past(|(interrupt_flags & interrupt_enable))
        && !$past(main_control[rcr_pkg::CTL_CLOCK_OUTPUT_SEL]))
        else $error("interrupt raised without enabled flag");
    a_irq_clockout: assert property (
        main_control[rcr_pkg::CTL_CLOCK_OUTPUT_SEL] |=> !irq_out)
        else $error("interrupt raised in clock output mode");

    c_irq_rise: cover property ($rose(irq_out));
    c_flag_write: cover property (wr_strobe && addr == rcr_pkg::OFS_INTERRUPT_FLAGS);
    c_read_cmd: cover property (rx_valid && rx_first && rx_byte[7]);
endmodule

// ---- logic/rcr_serial_link.sv ----
/*
 * Serial slave front end: pin synchronisers, byte framing and shifting.
 * Assumes mode 0 framing, MSB first, each clock half-period at least
 * five system cycles so byte data is ready before the next falling edge.
 */
module rcr_serial_link
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic [7:0] tx_byte_in,
    output logic rx_valid_out,
    output logic rx_first_out,
    output logic [7:0] rx_byte_out,
    output logic frame_active_out,
    output logic sdo_out,
    output logic sdo_oe_out
);
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    logic [2:0] filt_prev;
    logic [2:0] bit_cnt;
    logic first_byte;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic sclk_rise;
    logic sclk_fall;
    logic active;

    // --------------------------------------------------------------
    // Pin synchronisers, filtered on agreement of stages two and three
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            s1 <= 3'h2;
            s2 <= 3'h2;
            s3 <= 3'h2;
            filt <= 3'h2;
            filt_prev <= 3'h2;
        end
        else
        begin
            s1 <= {mosi_in, cs_n_in, sclk_in};
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < 3; i++)
            begin
                if (s2[i] == s3[i])
                begin
                    filt[i] <= s3[i];
                end
            end
            filt_prev <= filt;
        end
    end

    assign active = !filt[1];
    assign sclk_rise = active && filt[0] && !filt_prev[0];
    assign sclk_fall = active && !filt[0] && filt_prev[0];

    // --------------------------------------------------------------
    // Receive shifting
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || !active)
        begin
            bit_cnt <= 3'h0;
            first_byte <= 1'b1;
            rx_sh <= 8'h00;
            rx_valid_out <= 1'b0;
            rx_first_out <= 1'b0;
            rx_byte_out <= 8'h00;
        end
        else
        begin
            rx_valid_out <= 1'b0;
            if (sclk_rise)
            begin
                rx_sh <= {rx_sh[6:0], filt[2]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7)
                begin
                    rx_valid_out <= 1'b1;
                    rx_first_out <= first_byte;
                    rx_byte_out <= {rx_sh[6:0], filt[2]};
                    first_byte <= 1'b0;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Transmit shifting; a new byte loads on the falling edge after a
    // completed byte, so the command byte itself returns zeros
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || !active)
        begin
            tx_sh <= 8'h00;
        end
        else if (sclk_fall)
        begin
            if (bit_cnt == 3'h0 && !first_byte)
            begin
                tx_sh <= tx_byte_in;
            end
            else
            begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    assign sdo_out = tx_sh[7];
    assign sdo_oe_out = active;
    assign frame_active_out = active;
endmodule

// ---- pkg/rcr_pkg.sv ----
/*
 * Constants for the control-page register group of the clock.
 * Assumes byte-wide registers reached over a four-wire serial link.
 */
package rcr_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [5:0] OFS_MAIN_CONTROL = 6'h00;
    localparam logic [5:0] OFS_INTERRUPT_ENABLE = 6'h01;
    localparam logic [5:0] OFS_INTERRUPT_FLAGS = 6'h02;

    // --------------------------------------------------------------
    // Serial command byte layout
    // --------------------------------------------------------------
    localparam int CMD_READ_BIT = 7;
    localparam int ADDR_W = 6;

    // --------------------------------------------------------------
    // Main control fields
    // --------------------------------------------------------------
    localparam int CTL_CLOCK_OUTPUT_SEL = 7;
    localparam int CTL_TIMER_SOURCE_HI = 6;
    localparam int CTL_TIMER_SOURCE_LO = 5;
    localparam int CTL_SELF_RECOVERY_EN = 4;
    localparam int CTL_HOURLY_REFRESH_EN = 3;
    localparam int CTL_TIMER_AUTORELOAD = 2;
    localparam int CTL_COUNTDOWN_EN = 1;
    localparam int CTL_WATCH_TICK_EN = 0;

    // --------------------------------------------------------------
    // Enable and flag fields (same positions in both registers)
    // --------------------------------------------------------------
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_COUNTDOWN = 1;
    localparam int IRQ_LOW_VOLT_ONE = 2;
    localparam int IRQ_LOW_VOLT_TWO = 3;
    localparam int IRQ_SELF_RECOVERY = 4;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h1F;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_FLAGS = 8'h00;
endpackage

// ---- verification/rcr_host_model.sv ----
/*
 * Host side of the four-wire serial link: a mode 0 master, MSB first.
 * Assumes the bench calls its tasks from one process, starting at a clock edge.
 */
module rcr_host_model
#(
    parameter int HALF = 6
)
(
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_byte_out = 8'h00;
    end

    // --------------------------------------------------------------
    // Framing
    // --------------------------------------------------------------
    // Released data line flips so a stale level is never mistaken for data
    task automatic frame(input logic on);
        repeat (HALF) @(posedge clk_in);
        cs_n_out <= ~on;
        if (!on)
            mosi_out <= ~mosi_out;
        repeat (HALF) @(posedge clk_in);
    endtask

    // --------------------------------------------------------------
    // One byte each way
    // --------------------------------------------------------------
    task automatic xfer(input logic [7:0] tx, input logic capture);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_out <= tx[i];
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b1;
            rx[i] = miso_in;
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        if (capture)
        begin
            rx_byte_out <= rx;
            rx_valid_out <= 1'b1;
            @(posedge clk_in);
            rx_valid_out <= 1'b0;
        end
    endtask
endmodule

// ---- verification/testbench.sv ----
/*
 * Self-checking bench for the control-page registers.
 * Assumes the host model for serial access and drives event pulses itself.
 */
`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("MISMATCH time=%0t got=%h expected=%h", $time, g, e); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [4:0] ev = 5'h00;
    logic sclk, cs_n, mosi, sdo, sdo_oe, irq, rx_valid;
    logic [7:0] rx_byte, r, exp_b;
    // Slices of it are driven by separate output ports (bits 6:5 by one port), so this must be a net
    wire logic [7:0] ctl_bits;
    int failures = 0;
    int checks_done = 0;
    logic [7:0] exp_q[$];
    wire logic miso = sdo_oe ? sdo : 1'bz;

    always #2 clk_sys_in = ~clk_sys_in;

    rcr_control_regs dut
    (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .mosi_in(mosi), .alarm_match_in(ev[0]), .countdown_zero_in(ev[1]),
        .low_volt_threshold_one_in(ev[2]), .low_volt_threshold_two_in(ev[3]),
        .self_recovery_in(ev[4]), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .irq_out(irq),
        .clock_output_pin_sel_out(ctl_bits[7]), .timer_source_select_out(ctl_bits[6:5]),
        .self_recovery_enable_out(ctl_bits[4]), .hourly_refresh_enable_out(ctl_bits[3]),
        .timer_autoreload_enable_out(ctl_bits[2]), .countdown_enable_out(ctl_bits[1]),
        .watch_tick_enable_out(ctl_bits[0])
    );

    rcr_host_model #(.HALF(6)) host
    (
        .clk_in(clk_sys_in), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte)
    );

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic access(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                          input int n, input logic cap);
        host.frame(1'b1);
        host.xfer(cmd, 1'b0);
        for (int i = 0; i < n; i++)
            host.xfer((i == 0) ? d0 : d1, cap);
        host.frame(1'b0);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        access({2'b00, a}, d, 8'h00, 1, 1'b0);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        access({2'b10, a}, 8'h00, 8'h00, 1, 1'b1);
    endtask

    // Flag sets one edge after the pulse, interrupt one edge later
    task automatic pulse(input logic [4:0] p);
        @(posedge clk_sys_in);
        ev <= p;
        @(posedge clk_sys_in);
        ev <= 5'h00;
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Read result monitor
    // --------------------------------------------------------------
    always @(posedge clk_sys_in)
    begin
        if (rx_valid === 1'b1)
        begin
            exp_b = exp_q.pop_front();
            `CHK(rx_byte, exp_b)
        end
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        failures++;
        wrap_up();
    end

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial
    begin
        void'($urandom(28438));
        repeat (10) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        rd(rcr_pkg::OFS_MAIN_CONTROL, rcr_pkg::RST_MAIN_CONTROL);
        rd(rcr_pkg::OFS_INTERRUPT_ENABLE, rcr_pkg::RST_INTERRUPT_ENABLE);
        rd(rcr_pkg::OFS_INTERRUPT_FLAGS, rcr_pkg::RST_INTERRUPT_FLAGS);
        rd(6'h05, 8'h00);
        r = 8'($urandom);
        wr(rcr_pkg::OFS_MAIN_CONTROL, r);
        `CHK(ctl_bits, r)
        rd(rcr_pkg::OFS_MAIN_CONTROL, r);
        // Auto-increment: enables then flags in one frame
        r = 8'($urandom);
        access({2'b00, rcr_pkg::OFS_INTERRUPT_ENABLE}, r, 8'hFF, 2, 1'b0);
        rd(rcr_pkg::OFS_INTERRUPT_ENABLE, r & rcr_pkg::IRQ_IMPL_MASK);
        rd(rcr_pkg::OFS_INTERRUPT_FLAGS, 8'h00);
        wr(rcr_pkg::OFS_MAIN_CONTROL, 8'h00);
        // Each source alone; disabled case keeps every other enable on
        for (int i = 0; i < 5; i++)
        begin
            for (int e = 0; e < 2; e++)
            begin
                r = 8'h01 << i;
                wr(rcr_pkg::OFS_INTERRUPT_ENABLE, (e == 1) ? r : (~r & 8'h1F));
                pulse(r[4:0]);
                `CHK(irq, (e == 1))
                rd(rcr_pkg::OFS_INTERRUPT_FLAGS, r);
                wr(rcr_pkg::OFS_INTERRUPT_FLAGS, 8'h00);
                `CHK(irq, 1'b0)
            end
        end
        // Clock output mode masks the interrupt
        wr(rcr_pkg::OFS_INTERRUPT_ENABLE, 8'h1F);
        pulse(5'h1F);
        `CHK(irq, 1'b1)
        wr(rcr_pkg::OFS_MAIN_CONTROL, 8'h80);
        `CHK(irq, 1'b0)
        rd(rcr_pkg::OFS_INTERRUPT_FLAGS, 8'h1F);
        wr(rcr_pkg::OFS_MAIN_CONTROL, 8'h00);
        `CHK(irq, 1'b1)
        repeat (20) @(posedge clk_sys_in);
        `CHK(exp_q.size(), 0)
        wrap_up();
    end
endmodule
